// ===== hw/nvd_dft.sv
/*
  one-cycle fourier filter: 16 samples per fundamental period, squared
  magnitude of the fundamental at the end of each window.
  assumes the sample strobe comes 16 times per power cycle, same clock.
*/
`timescale 1ns/1ns
module nvd_dft (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic signed [17:0] sample,
  output logic mag_valid,
  output logic [47:0] mag_sq
);
  logic [3:0] idx_reg; // position within the window
  logic signed [35:0] acc_re_reg; // cosine correlation
  logic signed [35:0] acc_im_reg; // sine correlation
  logic signed [31:0] prod_re;
  logic signed [31:0] prod_im;
  logic signed [35:0] sum_re;
  logic signed [35:0] sum_im;
  logic signed [23:0] re_reg; // finished real part
  logic signed [23:0] im_reg; // finished imaginary part
  logic fin_reg; // window just closed

  // cosine in q12, folded by symmetry onto nine values
  function automatic logic signed [13:0] cos_q12(input logic [3:0] k);
    logic [3:0] q;
    q = k[3] ? 4'(5'h10 - {1'b0, k}) : k;
    unique case (q)
      4'h0: cos_q12 = 14'sh1000;
      4'h1: cos_q12 = 14'sh0ec8;
      4'h2: cos_q12 = 14'sh0b50;
      4'h3: cos_q12 = 14'sh061f;
      4'h4: cos_q12 = 14'sh0000;
      4'h5: cos_q12 = -14'sh061f;
      4'h6: cos_q12 = -14'sh0b50;
      4'h7: cos_q12 = -14'sh0ec8;
      4'h8: cos_q12 = -14'sh1000;
      default: cos_q12 = 14'sh0000;
    endcase
  endfunction

  // a full-period window nulls every harmonic except 16n plus or minus 1, which alias onto the fundamental; the third is nulled
  assign prod_re = sample * cos_q12(idx_reg);
  assign prod_im = sample * cos_q12(4'(idx_reg - 4'h4));
  assign sum_re = acc_re_reg + 36'(prod_re);
  assign sum_im = acc_im_reg + 36'(prod_im);

  // accumulate and close the window
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idx_reg <= 4'h0;
      acc_re_reg <= 36'sh0;
      acc_im_reg <= 36'sh0;
      re_reg <= 24'sh0;
      im_reg <= 24'sh0;
      fin_reg <= 1'b0;
    end else begin
      fin_reg <= 1'b0;
      if (sample_valid) begin
        idx_reg <= 4'(idx_reg + 4'h1);
        if (idx_reg == 4'hf) begin
          // last sample: drop the coefficient scale and restart
          re_reg <= 24'(sum_re >>> 12);
          im_reg <= 24'(sum_im >>> 12);
          acc_re_reg <= 36'sh0;
          acc_im_reg <= 36'sh0;
          fin_reg <= 1'b1;
        end else begin
          acc_re_reg <= sum_re;
          acc_im_reg <= sum_im;
        end
      end
    end
  end

  // squared magnitude, no root needed for comparison
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mag_valid <= 1'b0;
      mag_sq <= 48'h0;
    end else begin
      mag_valid <= fin_reg;
      if (fin_reg) begin
        // widen before squaring, a 24-bit product would wrap
        mag_sq <= 48'(48'(re_reg) * 48'(re_reg)) + 48'(48'(im_reg) * 48'(im_reg));
      end
    end
  end

  window_close_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sample_valid && idx_reg == 4'hf |=> fin_reg ##1 mag_valid)
    else $error("window did not close after sixteen samples");
endmodule

// ===== hw/nvd_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  neutral voltage displacement block.
  assumes a 250 MHz system clock and an APB master with 32-bit data.
*/
// Operation
// - stage starts when residual exceeds threshold
// - start persisting past delay gives trip
// - fundamental only, third harmonic rejected
// - calculated mode sums the three phases
// - calculated thresholds scale to phase reference
// - measured mode uses residual input, reference
// - two stages, low and high, fixed delay
// - four setting groups, one active
// - low delay 0.3 to 300 s
// - high delay 0.08 to 300 s
`ifndef NVD_MAP_SVH
`define NVD_MAP_SVH

// register byte offsets
`define NVD_OFS_CTRL 8'h00
`define NVD_OFS_REF_CALC 8'h04
`define NVD_OFS_REF_MEAS 8'h08
`define NVD_OFS_LOW_SET 8'h10
`define NVD_OFS_HIGH_SET 8'h20
`define NVD_OFS_STATUS 8'h30
`define NVD_OFS_EVT_STATUS 8'h34
`define NVD_OFS_EVT_CLEAR 8'h38
`define NVD_OFS_EVT_ENABLE 8'h3c
`define NVD_OFS_MAG 8'h40

// control fields
`define NVD_CTRL_MODE 0
`define NVD_CTRL_GRP_LO 1
`define NVD_CTRL_GRP_HI 2
`define NVD_CTRL_EVT_EN 3
`define NVD_CTRL_LOW_EN 4
`define NVD_CTRL_HIGH_EN 5

// setting word fields
`define NVD_SET_PCT_HI 5
`define NVD_SET_DLY_LO 16
`define NVD_SET_DLY_HI 29

// setting limits, threshold in percent, delays in steps
`define NVD_PCT_MIN 14'h0001
`define NVD_PCT_MAX 14'h003c
`define NVD_LOW_DLY_MIN 14'h0003
`define NVD_LOW_DLY_MAX 14'h0bb8
`define NVD_HIGH_DLY_MIN 14'h0004
`define NVD_HIGH_DLY_MAX 14'h3a98

// reset values
`define NVD_RST_CTRL 6'h38
`define NVD_RST_REF 16'h0100
`define NVD_RST_PCT 6'h14
`define NVD_RST_LOW_DLY 14'h001e
`define NVD_RST_HIGH_DLY 14'h0019

// timing: clock rate and delay step sizes
`define NVD_CLK_MHZ 250
`define NVD_LOW_STEP_MS 100
`define NVD_HIGH_STEP_MS 20

`endif

// ===== hw/nvd_pkg.sv
/*
  types shared by the neutral voltage displacement block.
  assumes nothing of its surroundings.
*/
package nvd_pkg;
  // state of one protection stage
  typedef enum logic [1:0] {
    nvd_st_idle = 2'b00,
    nvd_st_started = 2'b01,
    nvd_st_tripped = 2'b10
  } nvd_stage_st_t;
  // source of the residual voltage
  typedef enum logic {
    nvd_measured_residual_mode = 1'b0,
    nvd_calculated_residual_mode = 1'b1
  } nvd_mode_t;
endpackage

// ===== hw/nvd_stage.sv
/*
  one fixed delay stage: start, release with 0.97 reset ratio, trip timer.
  assumes a squared magnitude strobe and a threshold in the same units.
*/
`timescale 1ns/1ns
module nvd_stage #(
  parameter int TICK_CYC = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mag_valid,
  input wire logic [47:0] mag_sq,
  input wire logic [21:0] thr,
  input wire logic [13:0] delay_steps,
  input wire logic block,
  output logic start_out,
  output logic trip_out,
  output logic start_evt,
  output logic trip_evt
);
  nvd_pkg::nvd_stage_st_t state_reg;
  nvd_pkg::nvd_stage_st_t state_next;
  logic [24:0] tick_reg; // cycles within one delay step
  logic [13:0] step_reg; // elapsed delay steps
  logic [21:0] thr_off; // release level, about 97 percent
  logic [47:0] thr_on_sq;
  logic [47:0] thr_off_sq;
  logic above;
  logic below;

  assign thr_off = thr - 22'((32'(thr) * 32'd31) >> 10);
  assign thr_on_sq = 48'(thr) * 48'(thr);
  assign thr_off_sq = 48'(thr_off) * 48'(thr_off);
  assign above = mag_valid && (mag_sq > thr_on_sq);
  assign below = mag_valid && (mag_sq < thr_off_sq);

  // next state
  always_comb begin
    state_next = state_reg;
    if (block) begin
      state_next = nvd_pkg::nvd_st_idle;
    end else begin
      unique case (state_reg)
        nvd_pkg::nvd_st_idle: begin
          if (above) state_next = nvd_pkg::nvd_st_started;
        end
        nvd_pkg::nvd_st_started: begin
          if (below) begin
            state_next = nvd_pkg::nvd_st_idle;
          end else if (step_reg >= delay_steps) begin
            state_next = nvd_pkg::nvd_st_tripped;
          end
        end
        nvd_pkg::nvd_st_tripped: begin
          if (below) state_next = nvd_pkg::nvd_st_idle;
        end
        default: state_next = nvd_pkg::nvd_st_idle;
      endcase
    end
  end

  // state and registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= nvd_pkg::nvd_st_idle;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      start_evt <= 1'b0;
      trip_evt <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_out <= state_next != nvd_pkg::nvd_st_idle;
      trip_out <= state_next == nvd_pkg::nvd_st_tripped;
      start_evt <= state_reg == nvd_pkg::nvd_st_idle && state_next != nvd_pkg::nvd_st_idle;
      trip_evt <= state_reg != nvd_pkg::nvd_st_tripped && state_next == nvd_pkg::nvd_st_tripped;
    end
  end

  // delay timer runs only while started, cleared otherwise
  always_ff @(posedge clk_sys) begin
    if (!rstn || state_reg != nvd_pkg::nvd_st_started || block) begin
      tick_reg <= 25'h0;
      step_reg <= 14'h0;
    end else if (tick_reg == 25'(TICK_CYC - 1)) begin
      tick_reg <= 25'h0;
      step_reg <= 14'(step_reg + 14'h1);
    end else begin
      tick_reg <= 25'(tick_reg + 25'h1);
    end
  end

  block_clears_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    block |=> !start_out && !trip_out && step_reg == 14'h0)
    else $error("blocking did not clear the stage");
  start_above_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !block && !start_out && above |=> start_out && start_evt)
    else $error("stage did not start above threshold");
  trip_after_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(trip_out) |-> $past(step_reg) >= $past(delay_steps) && start_out)
    else $error("trip without elapsed delay");
  release_resets_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    start_out && below |=> !start_out ##1 step_reg == 14'h0)
    else $error("release did not reset the timer");
  trip_seen_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(trip_out));
  block_start_c: cover property (@(posedge clk_sys) disable iff (!rstn) start_out && block);
endmodule

// ===== hw/nvd_top.sv
/*
  neutral voltage displacement protection with low-set and high-set stages,
  apb register file, event status and interrupt.
  assumes voltage samples from a front end on clk_sys, 16 strobes per power
  cycle, and block pins from outside the clock domain.
*/
`timescale 1ns/1ns
`include "nvd_map.svh"
module nvd_top #(
  parameter int LOW_TICK_CYC = `NVD_LOW_STEP_MS * 1000 * `NVD_CLK_MHZ,
  parameter int HIGH_TICK_CYC = `NVD_HIGH_STEP_MS * 1000 * `NVD_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic signed [15:0] phase_a,
  input wire logic signed [15:0] phase_b,
  input wire logic signed [15:0] phase_c,
  input wire logic signed [15:0] residual_in,
  input wire logic block_low,
  input wire logic block_high,
  output logic low_start,
  output logic low_trip,
  output logic high_start,
  output logic high_trip,
  output logic irq
);
  // control and settings
  logic [5:0] ctrl_reg; // mode, group, event enable, stage enables
  logic [15:0] ref_calc_reg; // reference in calculated mode
  logic [15:0] ref_meas_reg; // reference in measured mode
  logic [5:0] low_pct_reg [4]; // low stage threshold per group
  logic [13:0] low_dly_reg [4]; // low stage delay per group
  logic [5:0] high_pct_reg [4];
  logic [13:0] high_dly_reg [4];
  logic [3:0] evt_reg; // sticky events
  logic [3:0] evt_next;
  logic [3:0] evt_set;
  logic [3:0] evt_clr;
  logic [3:0] irq_en_reg;
  // block pin synchronisers
  logic [1:0] blk_meta_reg;
  logic [1:0] blk_sync_reg;
  // residual path
  logic signed [17:0] phase_sum;
  logic signed [17:0] res_sample_reg;
  logic res_valid_reg;
  logic mag_valid;
  logic [47:0] mag_sq;
  // active settings
  logic [1:0] grp;
  logic [15:0] ref_sel;
  logic [21:0] low_thr;
  logic [21:0] high_thr;
  logic low_start_evt;
  logic low_trip_evt;
  logic high_start_evt;
  logic high_trip_evt;
  // bus strobes
  logic setup;
  logic wr_en;
  logic addr_ok;
  logic [13:0] wr_pct;
  logic [13:0] wr_low_dly;
  logic [13:0] wr_high_dly;

  // keep a written value within its legal range
  function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo,
                                        input logic [13:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // whether an offset is one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `NVD_OFS_CTRL) || (a == `NVD_OFS_REF_CALC) || (a == `NVD_OFS_REF_MEAS)
      || (a[7:4] == `NVD_OFS_LOW_SET >> 4) || (a[7:4] == `NVD_OFS_HIGH_SET >> 4)
      || (a == `NVD_OFS_STATUS) || (a == `NVD_OFS_EVT_STATUS)
      || (a == `NVD_OFS_EVT_CLEAR) || (a == `NVD_OFS_EVT_ENABLE) || (a == `NVD_OFS_MAG);
    mapped = mapped && (a[1:0] == 2'b00);
  endfunction

  assign grp = ctrl_reg[`NVD_CTRL_GRP_HI:`NVD_CTRL_GRP_LO];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign addr_ok = mapped(paddr);
  assign wr_pct = clamp({8'h0, pwdata[`NVD_SET_PCT_HI:0]}, `NVD_PCT_MIN, `NVD_PCT_MAX);
  assign wr_low_dly = clamp(pwdata[`NVD_SET_DLY_HI:`NVD_SET_DLY_LO], `NVD_LOW_DLY_MIN,
                            `NVD_LOW_DLY_MAX);
  assign wr_high_dly = clamp(pwdata[`NVD_SET_DLY_HI:`NVD_SET_DLY_LO], `NVD_HIGH_DLY_MIN,
                             `NVD_HIGH_DLY_MAX);

  // control and reference registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_reg <= `NVD_RST_CTRL;
      ref_calc_reg <= `NVD_RST_REF;
      ref_meas_reg <= `NVD_RST_REF;
      irq_en_reg <= 4'h0;
    end else if (wr_en) begin
      if (paddr == `NVD_OFS_CTRL) ctrl_reg <= pwdata[5:0];
      if (paddr == `NVD_OFS_REF_CALC) ref_calc_reg <= pwdata[15:0];
      if (paddr == `NVD_OFS_REF_MEAS) ref_meas_reg <= pwdata[15:0];
      if (paddr == `NVD_OFS_EVT_ENABLE) irq_en_reg <= pwdata[3:0];
    end
  end

  // four setting groups per stage, written with range clamping
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        low_pct_reg[i] <= `NVD_RST_PCT;
        low_dly_reg[i] <= `NVD_RST_LOW_DLY;
        high_pct_reg[i] <= `NVD_RST_PCT;
        high_dly_reg[i] <= `NVD_RST_HIGH_DLY;
      end
    end else if (wr_en && paddr[1:0] == 2'b00) begin
      if (paddr[7:4] == `NVD_OFS_LOW_SET >> 4) begin
        low_pct_reg[paddr[3:2]] <= wr_pct[5:0];
        low_dly_reg[paddr[3:2]] <= wr_low_dly;
      end
      if (paddr[7:4] == `NVD_OFS_HIGH_SET >> 4) begin
        high_pct_reg[paddr[3:2]] <= wr_pct[5:0];
        high_dly_reg[paddr[3:2]] <= wr_high_dly;
      end
    end
  end

  // two-flop synchronisers for the block pins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      blk_meta_reg <= 2'b00;
      blk_sync_reg <= 2'b00;
    end else begin
      blk_meta_reg <= {block_high, block_low};
      blk_sync_reg <= blk_meta_reg;
    end
  end

  // residual source: phase sum or the dedicated input
  assign phase_sum = {{2{phase_a[15]}}, phase_a} + {{2{phase_b[15]}}, phase_b}
    + {{2{phase_c[15]}}, phase_c};
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      res_sample_reg <= 18'sh0;
      res_valid_reg <= 1'b0;
    end else begin
      res_valid_reg <= sample_valid;
      if (sample_valid) begin
        if (ctrl_reg[`NVD_CTRL_MODE] == nvd_pkg::nvd_calculated_residual_mode) begin
          res_sample_reg <= phase_sum;
        end else begin
          res_sample_reg <= {{2{residual_in[15]}}, residual_in};
        end
      end
    end
  end

  // fundamental filter
  nvd_dft u_dft (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sample_valid(res_valid_reg),
    .sample(res_sample_reg),
    .mag_valid(mag_valid),
    .mag_sq(mag_sq)
  );

  // thresholds of the active group in magnitude units
  assign ref_sel = (ctrl_reg[`NVD_CTRL_MODE] == nvd_pkg::nvd_calculated_residual_mode)
    ? ref_calc_reg : ref_meas_reg;
  assign low_thr = 22'(low_pct_reg[grp]) * 22'(ref_sel);
  assign high_thr = 22'(high_pct_reg[grp]) * 22'(ref_sel);

  // low-set and high-set stages, each a fixed delay stage
  nvd_stage #(.TICK_CYC(LOW_TICK_CYC)) u_low (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mag_valid(mag_valid),
    .mag_sq(mag_sq),
    .thr(low_thr),
    .delay_steps(low_dly_reg[grp]),
    .block(blk_sync_reg[0] || !ctrl_reg[`NVD_CTRL_LOW_EN]),
    .start_out(low_start),
    .trip_out(low_trip),
    .start_evt(low_start_evt),
    .trip_evt(low_trip_evt)
  );
  nvd_stage #(.TICK_CYC(HIGH_TICK_CYC)) u_high (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mag_valid(mag_valid),
    .mag_sq(mag_sq),
    .thr(high_thr),
    .delay_steps(high_dly_reg[grp]),
    .block(blk_sync_reg[1] || !ctrl_reg[`NVD_CTRL_HIGH_EN]),
    .start_out(high_start),
    .trip_out(high_trip),
    .start_evt(high_start_evt),
    .trip_evt(high_trip_evt)
  );

  // event logging: gated by event enable, set wins over clear
  assign evt_set = {high_trip_evt, high_start_evt, low_trip_evt, low_start_evt}
    & {4{ctrl_reg[`NVD_CTRL_EVT_EN]}};
  assign evt_clr = (wr_en && paddr == `NVD_OFS_EVT_CLEAR) ? pwdata[3:0] : 4'h0;
  assign evt_next = (evt_reg & ~evt_clr) | evt_set;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      evt_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      evt_reg <= evt_next;
      irq <= |(evt_next & irq_en_reg);
    end
  end

  // apb slave: answer one cycle after setup, read data latched at setup
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      prdata <= 32'h0;
      if (setup && !pwrite) begin
        if (paddr == `NVD_OFS_CTRL) prdata <= {26'h0, ctrl_reg};
        if (paddr == `NVD_OFS_REF_CALC) prdata <= {16'h0, ref_calc_reg};
        if (paddr == `NVD_OFS_REF_MEAS) prdata <= {16'h0, ref_meas_reg};
        if (paddr[7:4] == `NVD_OFS_LOW_SET >> 4) begin
          prdata <= {2'h0, low_dly_reg[paddr[3:2]], 10'h0, low_pct_reg[paddr[3:2]]};
        end
        if (paddr[7:4] == `NVD_OFS_HIGH_SET >> 4) begin
          prdata <= {2'h0, high_dly_reg[paddr[3:2]], 10'h0, high_pct_reg[paddr[3:2]]};
        end
        if (paddr == `NVD_OFS_STATUS) begin
          prdata <= {26'h0, blk_sync_reg, high_trip, high_start, low_trip, low_start};
        end
        if (paddr == `NVD_OFS_EVT_STATUS) prdata <= {28'h0, evt_reg};
        if (paddr == `NVD_OFS_EVT_ENABLE) prdata <= {28'h0, irq_en_reg};
        if (paddr == `NVD_OFS_MAG) prdata <= mag_sq[47:16];
      end
    end
  end

  low_pct_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    low_pct_reg[grp] >= 6'h01 && low_pct_reg[grp] <= 6'h3c)
    else $error("low threshold out of range");
  low_dly_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    low_dly_reg[grp] >= 14'h0003 && low_dly_reg[grp] <= 14'h0bb8)
    else $error("low delay out of range");
  high_dly_range_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    high_dly_reg[grp] >= 14'h0004 && high_dly_reg[grp] <= 14'h3a98)
    else $error("high delay out of range");
  calc_sample_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sample_valid && ctrl_reg[0] |=> res_sample_reg == $past(phase_sum))
    else $error("calculated mode did not sum the phases");
  meas_sample_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sample_valid && !ctrl_reg[0] |=> res_sample_reg == 18'($past(residual_in)))
    else $error("measured mode did not take the residual input");
  calc_scale_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_reg[0] |-> low_thr == 22'(low_pct_reg[grp]) * 22'(ref_calc_reg))
    else $error("calculated mode threshold not scaled to its reference");
  evt_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ctrl_reg[3] && !(|evt_clr) |=> evt_reg == $past(evt_reg))
    else $error("event logged while reporting disabled");
  low_trip_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(low_trip));
  high_trip_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(high_trip));
  evt_clear_c: cover property (@(posedge clk_sys) disable iff (!rstn) |(evt_reg & evt_clr));
endmodule

// ===== test/nvd_front_model.sv
/*
  voltage transformer front end model: one strobe every 4 clocks, 16 per cycle.
  assumes the bench sets amplitude and harmonic choice between windows.
*/
`timescale 1ns/1ns
module nvd_front_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] amp,
  input wire logic harm,
  output logic sample_valid,
  output logic signed [15:0] phase_a,
  output logic signed [15:0] phase_b,
  output logic signed [15:0] phase_c,
  output logic signed [15:0] residual_in
);
  // one period of a sine, scaled by 1000
  localparam int TAB[16] = '{0, 383, 707, 924, 1000, 924, 707, 383,
                             0, -383, -707, -924, -1000, -924, -707, -383};
  logic [5:0] ph; // strobe divider and table index
  int v; // current sample value
  // harmonic mode steps the table three times as fast
  always_comb v = $signed({16'h0, amp}) * TAB[harm ? (3 * ph[5:2]) % 16 : ph[5:2]] / 1000;
  // between strobes the lines carry the inverse, not a stale sample
  always_ff @(posedge clk_sys) begin
    ph <= rstn ? ph + 6'h01 : 6'h00;
    sample_valid <= rstn && (ph[1:0] == 2'h3);
    residual_in <= (ph[1:0] == 2'h3) ? v[15:0] : ~v[15:0];
    phase_a <= (ph[1:0] == 2'h3) ? v[15:0] : ~v[15:0];
    phase_b <= (ph[1:0] == 2'h3) ? v[15:0] : ~v[15:0];
    phase_c <= (ph[1:0] == 2'h3) ? v[15:0] : ~v[15:0];
  end
endmodule

// ===== test/testbench.sv
/*
  self-checking bench: apb register tasks, stage start, trip, block, modes.
  assumes short tick parameters so delays last a few clock cycles.
*/
`timescale 1ns/1ns
module testbench;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, sample_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic signed [15:0] phase_a, phase_b, phase_c, residual_in;
  logic block_low, block_high, low_start, low_trip, high_start, high_trip, irq, e, harm;
  logic [15:0] amp;
  logic [3:0] outs; // stage outputs by index
  int n_errors, comparisons, cycles;
  localparam int TIMEOUT = 20000;
  assign outs = {high_trip, high_start, low_trip, low_start};
  nvd_top #(.LOW_TICK_CYC(4), .HIGH_TICK_CYC(2)) nvd_top_i (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c), .residual_in(residual_in),
    .block_low(block_low), .block_high(block_high), .low_start(low_start),
    .low_trip(low_trip), .high_start(high_start), .high_trip(high_trip), .irq(irq));
  nvd_front_model nvd_front_model_i (.clk_sys(clk_sys), .rstn(rstn), .amp(amp), .harm(harm),
    .sample_valid(sample_valid), .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
    .residual_in(residual_in));
  // clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // verdict and end of run
  task print_verdict();
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      n_errors++;
      print_verdict();
    end
  end
  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // wait a bounded time for a stage output to reach a level
  task automatic waitb(input int b, input logic v, input int lim);
    int i;
    i = 0;
    while (outs[b] !== v && i < lim) begin
      @(posedge clk_sys);
      i++;
    end
    chk({31'h0, outs[b]}, {31'h0, v});
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, block_low, block_high, harm} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    amp = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h00, 32'h38);
    apb(1'b0, 8'h44, 32'h0);
    chk({31'h0, e}, 32'h1);
    // setting limits of group 3, both stages
    wr(8'h1c, 32'h0);
    rd(8'h1c, 32'h0003_0001);
    wr(8'h1c, 32'h3fff_003f);
    rd(8'h1c, 32'h0bb8_003c);
    wr(8'h2c, 32'h0);
    rd(8'h2c, 32'h0004_0001);
    wr(8'h2c, 32'h3fff_003f);
    rd(8'h2c, 32'h3a98_003c);
    wr(8'h10, 32'h0003_0014);
    wr(8'h20, 32'h0004_0014);
    wr(8'h3c, 32'hf);
    // fault above both thresholds
    amp <= 16'd1000;
    waitb(0, 1'b1, 400);
    chk({31'h0, low_trip}, 32'h0);
    waitb(1, 1'b1, 40);
    waitb(3, 1'b1, 400);
    rd(8'h34, 32'hf);
    chk({31'h0, irq}, 32'h1);
    amp <= 16'd0;
    waitb(0, 1'b0, 300);
    chk({31'h0, low_trip}, 32'h0);
    wr(8'h38, 32'hf);
    rd(8'h34, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // low stage blocked, high stage free
    block_low <= 1'b1;
    amp <= 16'd1000;
    waitb(3, 1'b1, 500);
    chk({31'h0, low_start}, 32'h0);
    rd(8'h30, 32'h1c);
    block_low <= 1'b0;
    waitb(1, 1'b1, 300);
    amp <= 16'd0;
    waitb(2, 1'b0, 300);
    // third harmonic only at large amplitude, then a small fundamental below the low threshold
    harm <= 1'b1;
    amp <= 16'd2000;
    repeat (300) @(posedge clk_sys);
    chk({31'h0, high_start}, 32'h0);
    harm <= 1'b0;
    amp <= 16'd300;
    repeat (300) @(posedge clk_sys);
    chk({31'h0, low_start}, 32'h0);
    // group 1 with a low threshold
    wr(8'h14, 32'h0003_0001);
    wr(8'h00, 32'h3a);
    waitb(0, 1'b1, 400);
    wr(8'h00, 32'h38);
    waitb(0, 1'b0, 400);
    // calculated mode with events off
    wr(8'h00, 32'h31);
    wr(8'h38, 32'hf);
    waitb(0, 1'b1, 400);
    rd(8'h34, 32'h0);
    print_verdict();
  end
endmodule
